// *** shared/irq_mask_pkg.sv ***
// constants for the interrupt mask and product identification block
package irq_mask_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] FAULT_MASK_ADDR  = 8'h04;
  localparam logic [7:0] STATUS_MASK_ADDR = 8'h05;
  localparam logic [7:0] PRODUCT_ID_ADDR  = 8'h06;
  // fault mask bit positions
  localparam int unsigned LOCKOUT_BIT     = 6;
  localparam int unsigned IN_UV_BIT       = 5;
  localparam int unsigned IN_OV_BIT       = 4;
  localparam int unsigned SHORT_BIT       = 2;
  localparam int unsigned HS_OC_BIT       = 1;
  localparam int unsigned NEG_OC_BIT      = 0;
  // status mask bit positions
  localparam int unsigned TSD_BIT         = 6;
  localparam int unsigned TWARN_BIT       = 5;
  localparam int unsigned TPREW_BIT       = 4;
  localparam int unsigned BUS_ERR_BIT     = 2;
  localparam int unsigned CLK_SRC_BIT     = 1;
  localparam int unsigned PGOOD_BIT       = 0;
  // spare bits d7 and d3 always read one
  localparam logic [7:0] SPARE_ONES       = 8'h88;
  localparam logic [7:0] MASK_RESET       = 8'hff;
  // arbitrary neutral identification value
  localparam logic [7:0] PRODUCT_ID_DFLT  = 8'h5a;
  localparam logic [7:0] UNMAPPED_DATA    = 8'h00;
endpackage

// *** verilog/irq_mask_block.sv ***
// interrupt mask registers, product id and masked interrupt request
`timescale 1ns/1ps
module irq_mask_block
  import irq_mask_pkg::*;
#(
  parameter logic [7:0] PRODUCT_ID = PRODUCT_ID_DFLT
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  // pending fault and status events, latched elsewhere
  input  wire logic [7:0]        fault_pending,
  input  wire logic [7:0]        status_pending,
  // live source levels
  input  wire logic              sync_clock_active,
  input  wire logic              output_in_range,
  // indications and interrupt request
  output logic                   clock_source_indication,
  output logic                   power_good_indication,
  output logic                   irq_request
);

  logic [7:0] fault_interrupt_mask_ff;
  logic [7:0] status_interrupt_mask_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] fault_open;
  logic [7:0] status_open;
  logic       sync_meta_ff;
  logic       sync_ff;
  logic       pgood_meta_ff;
  logic       pgood_ff;
  logic [7:0] rdata_ff;
  logic       clock_source_indication_ff;
  logic       power_good_indication_ff;
  logic       irq_request_ff;

  // mask registers; spare bits forced to one
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_interrupt_mask_ff <= MASK_RESET;
    end else if (reg_wr && reg_addr == FAULT_MASK_ADDR) begin
      fault_interrupt_mask_ff <= reg_wdata | SPARE_ONES;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_interrupt_mask_ff <= MASK_RESET;
    end else if (reg_wr && reg_addr == STATUS_MASK_ADDR) begin
      status_interrupt_mask_ff <= reg_wdata | SPARE_ONES;
    end
  end

  // read mux; product id is constant so writes to it do nothing
  always_comb begin
    unique case (reg_addr)
      FAULT_MASK_ADDR:  nxt_rdata = fault_interrupt_mask_ff;
      STATUS_MASK_ADDR: nxt_rdata = status_interrupt_mask_ff;
      PRODUCT_ID_ADDR:  nxt_rdata = PRODUCT_ID;
      default:          nxt_rdata = UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= UNMAPPED_DATA;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // pin level synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_meta_ff  <= 1'b0;
      sync_ff       <= 1'b0;
      pgood_meta_ff <= 1'b0;
      pgood_ff      <= 1'b0;
    end else begin
      sync_meta_ff  <= sync_clock_active;
      sync_ff       <= sync_meta_ff;
      pgood_meta_ff <= output_in_range;
      pgood_ff      <= pgood_meta_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clock_source_indication_ff <= 1'b0;
      power_good_indication_ff   <= 1'b0;
    end else begin
      clock_source_indication_ff <= sync_ff;
      power_good_indication_ff   <= pgood_ff;
    end
  end

  // each source gated only by its own bit; spares never open
  assign fault_open  = fault_pending &
                       ~fault_interrupt_mask_ff;
  assign status_open = status_pending &
                       ~status_interrupt_mask_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_request_ff <= 1'b0;
    end else begin
      irq_request_ff <= |fault_open || |status_open;
    end
  end

  // every output port comes straight from its flop
  assign reg_rdata               = rdata_ff;
  assign clock_source_indication = clock_source_indication_ff;
  assign power_good_indication   = power_good_indication_ff;
  assign irq_request             = irq_request_ff;

  a_fault_spares: assert property (
    @(posedge clk) disable iff (rst)
    (fault_interrupt_mask_ff & SPARE_ONES) == SPARE_ONES)
    else $error("fault mask spare bit reads zero");

  a_fault_write: assert property (
    @(posedge clk) disable iff (rst)
    reg_wr && reg_addr == FAULT_MASK_ADDR |=>
    fault_interrupt_mask_ff == ($past(reg_wdata) | SPARE_ONES))
    else $error("fault mask write not stored");

  a_status_write: assert property (
    @(posedge clk) disable iff (rst)
    reg_wr && reg_addr == STATUS_MASK_ADDR |=>
    status_interrupt_mask_ff == ($past(reg_wdata) | SPARE_ONES))
    else $error("status mask write not stored");

  a_irq_open: assert property (
    @(posedge clk) disable iff (rst)
    (|(fault_pending & ~fault_interrupt_mask_ff)) |=> irq_request)
    else $error("unmasked fault did not raise interrupt");

  a_status_open: assert property (
    @(posedge clk) disable iff (rst)
    (|(status_pending & ~status_interrupt_mask_ff)) |=> irq_request)
    else $error("unmasked status event did not raise interrupt");

  a_irq_masked: assert property (
    @(posedge clk) disable iff (rst)
    !(|fault_open) && !(|status_open) |=> !irq_request)
    else $error("interrupt raised with all sources masked");

  a_spare_closed: assert property (
    @(posedge clk) disable iff (rst)
    (fault_pending & ~SPARE_ONES) == 8'h00 &&
    (status_pending & ~SPARE_ONES) == 8'h00 |=> !irq_request)
    else $error("spare pending bit raised interrupt");

  a_ov_own_bit: assert property (
    @(posedge clk) disable iff (rst)
    fault_pending == (8'h01 << IN_OV_BIT) && status_pending == 8'h00 &&
    !fault_interrupt_mask_ff[IN_OV_BIT] |=> irq_request)
    else $error("overvoltage gated by wrong bit");

  a_uv_own_bit: assert property (
    @(posedge clk) disable iff (rst)
    fault_pending == (8'h01 << IN_UV_BIT) && status_pending == 8'h00 &&
    fault_interrupt_mask_ff[IN_UV_BIT] |=> !irq_request)
    else $error("undervoltage leaked through mask");

  a_hs_own_bit: assert property (
    @(posedge clk) disable iff (rst)
    fault_pending == (8'h01 << HS_OC_BIT) && status_pending == 8'h00 &&
    fault_interrupt_mask_ff[HS_OC_BIT] |=> !irq_request)
    else $error("high-side overcurrent leaked through mask");

  a_neg_own_bit: assert property (
    @(posedge clk) disable iff (rst)
    fault_pending == (8'h01 << NEG_OC_BIT) && status_pending == 8'h00 &&
    fault_interrupt_mask_ff[NEG_OC_BIT] |=> !irq_request)
    else $error("negative overcurrent leaked through mask");

  a_tprew_own_bit: assert property (
    @(posedge clk) disable iff (rst)
    status_pending == (8'h01 << TPREW_BIT) && fault_pending == 8'h00 &&
    !status_interrupt_mask_ff[TPREW_BIT] |=> irq_request)
    else $error("prewarning gated by wrong bit");

  a_pid_read: assert property (
    @(posedge clk) disable iff (rst)
    reg_rd && reg_addr == PRODUCT_ID_ADDR |=> reg_rdata == PRODUCT_ID)
    else $error("product id read wrong");

  a_pid_write: assert property (
    @(posedge clk) disable iff (rst)
    reg_wr && reg_addr == PRODUCT_ID_ADDR |=>
    $stable(fault_interrupt_mask_ff) && $stable(status_interrupt_mask_ff))
    else $error("write to product id changed a mask");

  a_clk_ind: assert property (
    @(posedge clk) disable iff (rst)
    sync_clock_active [*4] |-> clock_source_indication)
    else $error("clock source indication not following pin");

  a_clk_low: assert property (
    @(posedge clk) disable iff (rst)
    !sync_clock_active [*4] |-> !clock_source_indication)
    else $error("clock source indication stuck at sync");

  a_pg_ind: assert property (
    @(posedge clk) disable iff (rst)
    !output_in_range [*4] |-> !power_good_indication)
    else $error("power good indication not following level");

  a_pg_high: assert property (
    @(posedge clk) disable iff (rst)
    output_in_range [*4] |-> power_good_indication)
    else $error("power good indication stuck low");

  c_fault_irq: cover property (@(posedge clk) disable iff (rst)
    |fault_open ##1 irq_request);
  c_status_irq: cover property (@(posedge clk) disable iff (rst)
    |status_open ##1 irq_request);
  c_mask_write: cover property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == FAULT_MASK_ADDR);
  c_pid_read: cover property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == PRODUCT_ID_ADDR);
  c_sync_seen: cover property (@(posedge clk) disable iff (rst)
    $rose(clock_source_indication));

endmodule

// *** test/host_model.sv ***
// host model that drives the register port at falling edges
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // released data shows a changed value, not the last one
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

// *** test/test_interrupt_mask_and_product_id.sv ***
// self-checking bench for the interrupt mask and product id block
`timescale 1ns/1ps
module test_interrupt_mask_and_product_id;
  import irq_mask_pkg::*;
  // arbitrary identification value
  localparam logic [7:0] PRODUCT_IDENTIFICATION = 8'h3c;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       sync_in = 1'b0;
  logic       in_rng = 1'b0;
  logic [7:0] fp = 8'h00;
  logic [7:0] sp = 8'h00;
  logic [7:0] addr, wdata, rdata, got;
  logic       wr, rd, ck_ind, pg_ind, irq;
  logic [9:0] m1, m2;
  logic [7:0] exp_irq;
  int         fault_model = int'(MASK_RESET);
  int         status_model = int'(MASK_RESET);
  int         n_errors = 0;
  int         n_checks = 0;
  int         cyc = 0;
  always #10 clk = ~clk;
  host_model u_host_model (.clk(clk), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata));
  irq_mask_block #(.PRODUCT_ID(PRODUCT_IDENTIFICATION)) u_irq_mask_block (.clk(clk),
    .rst(rst), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata(rdata), .fault_pending(fp),
    .status_pending(sp), .sync_clock_active(sync_in),
    .output_in_range(in_rng), .clock_source_indication(ck_ind),
    .power_good_indication(pg_ind), .irq_request(irq));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'h7add));
    repeat (10) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    check({7'h00, irq}, 8'h00);
    u_host_model.rd(FAULT_MASK_ADDR, got);
    check(got, MASK_RESET);
    u_host_model.rd(STATUS_MASK_ADDR, got);
    check(got, MASK_RESET);
    for (int i = 0; i < 60; i++) begin
      m1 = 10'($urandom);
      m2 = 10'($urandom);
      // one source alone first, so each mask bit is seen gating by itself
      fp = (i < 8) ? 8'h01 << i[2:0] : (i < 16) ? 8'h00 : 8'($urandom);
      sp = (i < 8) ? 8'h00 : (i < 16) ? 8'h01 << i[2:0] : 8'($urandom);
      fault_model = int'(m1[7:0] | SPARE_ONES);
      status_model = int'(m2[7:0] | SPARE_ONES);
      u_host_model.wr(FAULT_MASK_ADDR, m1[7:0]);
      u_host_model.wr(STATUS_MASK_ADDR, m2[7:0]);
      u_host_model.wr(PRODUCT_ID_ADDR, m1[7:0]);
      u_host_model.rd(FAULT_MASK_ADDR, got);
      check(got, 8'(fault_model));
      u_host_model.rd(STATUS_MASK_ADDR, got);
      check(got, 8'(status_model));
      u_host_model.rd(PRODUCT_ID_ADDR, got);
      check(got, PRODUCT_IDENTIFICATION);
      u_host_model.rd(8'h07 + 8'(i), got);
      check(got, UNMAPPED_DATA);
      exp_irq = {7'h00, |((fp & ~8'(fault_model)) |
        (sp & ~8'(status_model)))};
      check({7'h00, irq}, exp_irq);
      sync_in = m1[8];
      in_rng = m1[9];
      repeat (4) @(negedge clk);
      check({6'h00, ck_ind, pg_ind}, {6'h00, m1[8], m1[9]});
    end
    report_and_stop();
  end
endmodule
